// *** rtl/scsb_pkg.sv ***
// constants, types and clock mode decoding for the system clock select and boot block
// assumes one 100 MHz bus clock; oscillator outputs arrive as pins sampled on it
package scsb_pkg;

	// ----------------------------------------------------------------
	// bus and register map
	// ----------------------------------------------------------------
	localparam int SCSB_ADDR_W = 4;
	localparam int SCSB_DATA_W = 32;
	localparam logic [SCSB_ADDR_W-1:0] SCSB_OFS_CLKMD = 4'h0;
	localparam logic [SCSB_ADDR_W-1:0] SCSB_OFS_XTAL = 4'h4;
	localparam logic [SCSB_ADDR_W-1:0] SCSB_OFS_TRIM = 4'h8;
	localparam logic [SCSB_ADDR_W-1:0] SCSB_OFS_STATUS = 4'hc;
	localparam logic [1:0] SCSB_RESP_OKAY = 2'h0;
	localparam logic [1:0] SCSB_RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// register fields
	// ----------------------------------------------------------------
	localparam int SCSB_XTAL_EN_BIT = 7;
	localparam int SCSB_XTAL_DRV_LO = 5;
	localparam int SCSB_FAST_EN_BIT = 4;
	localparam int SCSB_SLOW_EN_BIT = 2;
	localparam int SCSB_SEL_HI = 7;
	localparam int SCSB_SEL_LO = 5;
	localparam int SCSB_SEL_B3 = 3;
	localparam logic [7:0] SCSB_XTAL_MASK = 8'he0;
	localparam int SCSB_ST_DONE = 0;
	localparam int SCSB_ST_SRC_LO = 1;
	localparam int SCSB_ST_WDT = 3;
	localparam int SCSB_ST_FASTOPT = 4;

	// ----------------------------------------------------------------
	// clock mode codes and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] SCSB_CLKMD_DIV2 = 8'h34;
	localparam logic [7:0] SCSB_CLKMD_DIV4 = 8'h14;
	localparam logic [7:0] SCSB_CLKMD_DIV8 = 8'h3c;
	localparam logic [7:0] SCSB_CLKMD_DIV16 = 8'h1c;
	localparam logic [7:0] SCSB_CLKMD_DIV32 = 8'h7c;
	localparam logic [7:0] SCSB_CLKMD_SLOW = 8'he4;
	// fast boot comes up on fast rc / 64, normal boot on slow rc, both rc on
	localparam logic [7:0] SCSB_CLKMD_RST_FAST = 8'h74;
	localparam logic [7:0] SCSB_CLKMD_RST_NORMAL = 8'hf4;
	localparam logic [7:0] SCSB_TRIM_RST = 8'h80;
	localparam logic [7:0] SCSB_XTAL_RST = 8'h00;

	// ----------------------------------------------------------------
	// boot timing, in slow rc cycles; the strap capture count is in aclk cycles
	// ----------------------------------------------------------------
	localparam int SCSB_BOOT_W = 12;
	localparam logic [SCSB_BOOT_W-1:0] SCSB_BOOT_FAST_LEN = 12'h02d;
	localparam logic [SCSB_BOOT_W-1:0] SCSB_BOOT_NORMAL_LEN = 12'hbb8;
	localparam logic [1:0] SCSB_CAPTURE_CYCLES = 2'h3;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {SCSB_SRC_FAST, SCSB_SRC_SLOW, SCSB_SRC_XTAL} scsb_src_t;
	typedef struct packed {
		scsb_src_t src;
		logic [2:0] div_log;
	} scsb_mode_t;
	typedef enum {SCSB_ST_CAPTURE, SCSB_ST_BOOT, SCSB_ST_RUN} scsb_state_t;

	function automatic scsb_mode_t scsb_decode(input logic [7:0] clkmd);
		scsb_mode_t m;
		m.src = SCSB_SRC_SLOW;
		m.div_log = 3'h0;
		case ({clkmd[SCSB_SEL_HI:SCSB_SEL_LO], clkmd[SCSB_SEL_B3]})
			4'h2: begin m.src = SCSB_SRC_FAST; m.div_log = 3'h1; end
			4'h0: begin m.src = SCSB_SRC_FAST; m.div_log = 3'h2; end
			4'h3: begin m.src = SCSB_SRC_FAST; m.div_log = 3'h3; end
			4'h1: begin m.src = SCSB_SRC_FAST; m.div_log = 3'h4; end
			4'h7: begin m.src = SCSB_SRC_FAST; m.div_log = 3'h5; end
			4'h6: begin m.src = SCSB_SRC_FAST; m.div_log = 3'h6; end
			4'ha: begin m.src = SCSB_SRC_XTAL; m.div_log = 3'h0; end
			default: begin m.src = SCSB_SRC_SLOW; m.div_log = 3'h0; end
		endcase
		return m;
	endfunction

endpackage

// *** rtl/scsb_clk_if.sv ***
// interface between the control top and the clock source selector
// assumes all signals live on the bus clock
`timescale 1ns/10ps
`default_nettype none
interface scsb_clk_if;
	import scsb_pkg::*;
	logic fast_edge;
	logic slow_edge;
	logic xtal_edge;
	logic restart;
	scsb_mode_t mode;
	logic tick;
	modport ctrl (output fast_edge, output slow_edge, output xtal_edge, output restart, output mode, input tick);
	modport sel (input fast_edge, input slow_edge, input xtal_edge, input restart, input mode, output tick);
endinterface
`default_nettype wire

// *** rtl/scsb_boot_counter.sv ***
// boot counter: counts slow rc edges after power-on and flags the end of boot
// assumes slow_edge is a one-cycle pulse already synchronised to aclk
`timescale 1ns/10ps
`default_nettype none
module scsb_boot_counter
	import scsb_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic start,
	input wire logic fast_opt,
	input wire logic slow_edge,
	output logic done
);
	logic [SCSB_BOOT_W-1:0] cnt_ff;
	logic done_ff;
	logic [SCSB_BOOT_W-1:0] len;

	assign len = fast_opt ? SCSB_BOOT_FAST_LEN : SCSB_BOOT_NORMAL_LEN;
	assign done = done_ff;

	// ----------------------------------------------------------------
	// count slow rc cycles
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_ff <= '0;
		end else if (start && !done_ff && slow_edge) begin
			cnt_ff <= cnt_ff + 12'h001; // RL16
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_ff <= 1'b0;
		end else if (start && cnt_ff == len) begin
			done_ff <= 1'b1; // RL3 RL16
		end
	end
endmodule
`default_nettype wire

// *** rtl/scsb_clk_sel.sv ***
// system clock selector: picks a source and divides it into a one-cycle tick
// assumes source edges are one-cycle pulses on aclk
`timescale 1ns/10ps
`default_nettype none
module scsb_clk_sel
	import scsb_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	scsb_clk_if.sel clk
);
	logic [5:0] div_cnt_ff;
	logic src_edge;
	logic [5:0] last;

	always_comb begin
		case (clk.mode.src)
			SCSB_SRC_FAST: src_edge = clk.fast_edge;
			SCSB_SRC_XTAL: src_edge = clk.xtal_edge;
			default: src_edge = clk.slow_edge;
		endcase
	end

	assign last = 6'((7'h01 << clk.mode.div_log) - 7'h01);
	assign clk.tick = src_edge && div_cnt_ff == last;

	// ----------------------------------------------------------------
	// divider
	// ----------------------------------------------------------------
	// a mode write restarts the divider so the new rate holds from the next edge
	always_ff @(posedge aclk) begin
		if (!aresetn || clk.restart) begin
			div_cnt_ff <= '0; // RL14
		end else if (clk.tick) begin
			div_cnt_ff <= '0;
		end else if (src_edge) begin
			div_cnt_ff <= div_cnt_ff + 6'h01; // RL6 RL7
		end
	end
endmodule
`default_nettype wire

// *** rtl/scsb_top.sv ***
// system clock select and boot control with an axi4-lite register slave
// assumes aresetn is the power-on reset and oscillator pins are asynchronous to aclk
//
// Summary of operation
// RL1: software turns the crystal, fast rc and slow rc oscillators on and off by their own enable bits.
// RL2: at the end of boot both rc oscillators run with no software write needed; a calibration load of the slow rc code at boot end leaves fast rc off.
// RL3: after power-on the core stays in reset for 45 slow rc cycles on fast boot or 3000 on normal boot.
// RL4: power-on reset starts the boot, whose length is chosen by a fast or normal boot option.
// RL5: a trim register tunes the fast rc frequency, usually to 16 MHz.
// RL6: clock mode codes 34h, 14h and 3Ch run the system on fast rc divided by 2, 4 and 8.
// RL7: clock mode codes 1Ch and 7Ch run the system on fast rc divided by 16 and 32.
// RL8: the slow rc code clocks the system from slow rc with fast rc off and the watchdog on.
// RL9: a divided fast rc setting applied at boot turns the watchdog off while slow rc stays on.
// RL10: with no calibration the clock mode keeps its reset value, slow rc or fast rc / 64, watchdog on.
// RL11: the programming tool picks a fast rc target of 14 to 18 MHz and a divisor of 2 to 32.
// RL12: calibration runs once while program memory is written, never on later boots.
// RL13: software should not rely on the slow rc for accurate timing.
// RL14: a write to the clock mode register switches the system clock at once.
// RL15: software switches away from a source before it disables that source.
// RL16: the boot counter runs on slow rc edges and releases reset only at the selected length.
`timescale 1ns/10ps
`default_nettype none
module scsb_top
	import scsb_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [scsb_pkg::SCSB_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [scsb_pkg::SCSB_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [scsb_pkg::SCSB_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [scsb_pkg::SCSB_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fast_rc_osc,
	input wire logic slow_rc_osc,
	input wire logic crystal_osc,
	input wire logic fast_boot_strap,
	input wire logic calibration_directive,
	input wire logic [7:0] calib_clkmd,
	input wire logic [7:0] calib_trim,
	output logic fast_rc_osc_en,
	output logic slow_rc_osc_en,
	output logic crystal_osc_en,
	output logic [1:0] crystal_drive,
	output logic [7:0] fast_rc_trim,
	output logic sys_clk_tick,
	output logic core_reset_n,
	output logic watchdog_en
);
	import scsb_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	localparam int NPIN = 4;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] sync1_ff;
	logic [NPIN-1:0] sync2_ff;
	logic [NPIN-1:0] sync3_ff;
	logic [NPIN-1:0] pin_rise;

	assign pin_raw = {fast_boot_strap, crystal_osc, slow_rc_osc, fast_rc_osc};

	// edges are taken from the second and third stages, never the first
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					sync1_ff[gi] <= 1'b0;
					sync2_ff[gi] <= 1'b0;
					sync3_ff[gi] <= 1'b0;
				end else begin
					sync1_ff[gi] <= pin_raw[gi];
					sync2_ff[gi] <= sync1_ff[gi];
					sync3_ff[gi] <= sync2_ff[gi];
				end
			end
			assign pin_rise[gi] = sync2_ff[gi] && !sync3_ff[gi];
		end
	endgenerate

	// ----------------------------------------------------------------
	// boot sequence
	// ----------------------------------------------------------------
	scsb_state_t state_ff;
	scsb_state_t nxt_state;
	logic [1:0] cap_cnt_ff;
	logic fast_opt_ff;
	logic boot_done;
	logic clkmd_wr;
	logic [7:0] clkmd_ff;
	logic [7:0] xtal_ff;
	logic [7:0] trim_ff;
	logic wdt_ff;
	logic core_rst_n_ff;
	scsb_mode_t cur_mode;
	scsb_mode_t calib_mode;

	assign cur_mode = scsb_decode(clkmd_ff);
	assign calib_mode = scsb_decode(calib_clkmd);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			SCSB_ST_CAPTURE: begin
				if (cap_cnt_ff == SCSB_CAPTURE_CYCLES) begin
					nxt_state = SCSB_ST_BOOT;
				end
			end
			SCSB_ST_BOOT: begin
				if (boot_done) begin
					nxt_state = SCSB_ST_RUN;
				end
			end
			SCSB_ST_RUN: nxt_state = SCSB_ST_RUN;
			default: nxt_state = SCSB_ST_CAPTURE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= SCSB_ST_CAPTURE; // RL4
		end else begin
			state_ff <= nxt_state;
		end
	end

	// the strap is read only once the synchroniser has filled after reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap_cnt_ff <= '0;
		end else if (state_ff == SCSB_ST_CAPTURE) begin
			cap_cnt_ff <= cap_cnt_ff + 2'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fast_opt_ff <= 1'b0;
		end else if (state_ff == SCSB_ST_CAPTURE && cap_cnt_ff == SCSB_CAPTURE_CYCLES) begin
			fast_opt_ff <= sync2_ff[3]; // RL4
		end
	end

	scsb_boot_counter u_boot (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(state_ff == SCSB_ST_BOOT),
		.fast_opt(fast_opt_ff),
		.slow_edge(pin_rise[1]),
		.done(boot_done)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_rst_n_ff <= 1'b0;
		end else begin
			core_rst_n_ff <= (nxt_state == SCSB_ST_RUN); // RL3
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite write channel
	// ----------------------------------------------------------------
	logic aw_held_ff;
	logic w_held_ff;
	logic [SCSB_ADDR_W-1:0] awaddr_ff;
	logic [7:0] wdata_ff;
	logic wstrb0_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic wr_fire;
	logic wr_lane;

	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready = !w_held_ff && !bvalid_ff;
	assign wr_fire = aw_held_ff && w_held_ff;
	assign wr_lane = wr_fire && wstrb0_ff;
	assign clkmd_wr = wr_lane && awaddr_ff == SCSB_OFS_CLKMD;

	always_ff @(posedge aclk) begin
		if (!aresetn || wr_fire) begin
			aw_held_ff <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_ff <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || wr_fire) begin
			w_held_ff <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_ff <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_ff <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awaddr_ff <= s_axi_awaddr;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdata_ff <= '0;
			wstrb0_ff <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wdata_ff <= s_axi_wdata[7:0];
			wstrb0_ff <= s_axi_wstrb[0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= SCSB_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= (awaddr_ff == SCSB_OFS_CLKMD || awaddr_ff == SCSB_OFS_XTAL ||
				awaddr_ff == SCSB_OFS_TRIM || awaddr_ff == SCSB_OFS_STATUS) ? SCSB_RESP_OKAY : SCSB_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clkmd_ff <= SCSB_CLKMD_RST_NORMAL;
		end else if (clkmd_wr) begin
			clkmd_ff <= wdata_ff; // RL1 RL14
		end else if (state_ff == SCSB_ST_CAPTURE && cap_cnt_ff == SCSB_CAPTURE_CYCLES) begin
			clkmd_ff <= sync2_ff[3] ? SCSB_CLKMD_RST_FAST : SCSB_CLKMD_RST_NORMAL; // RL10 RL2
		end else if (state_ff == SCSB_ST_BOOT && boot_done && calibration_directive) begin
			clkmd_ff <= calib_clkmd; // RL6 RL7 RL8
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xtal_ff <= SCSB_XTAL_RST;
		end else if (wr_lane && awaddr_ff == SCSB_OFS_XTAL) begin
			xtal_ff <= wdata_ff & SCSB_XTAL_MASK; // RL1
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trim_ff <= SCSB_TRIM_RST;
		end else if (wr_lane && awaddr_ff == SCSB_OFS_TRIM) begin
			trim_ff <= wdata_ff; // RL5
		end else if (state_ff == SCSB_ST_BOOT && boot_done && calibration_directive) begin
			trim_ff <= calib_trim; // RL5
		end
	end

	// watchdog follows the boot-time calibration choice only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdt_ff <= 1'b1; // RL10
		end else if (state_ff == SCSB_ST_BOOT && boot_done) begin
			wdt_ff <= !(calibration_directive && calib_mode.src == SCSB_SRC_FAST); // RL8 RL9
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	logic rvalid_ff;
	logic [SCSB_DATA_W-1:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic [SCSB_DATA_W-1:0] rd_mux;
	logic [1:0] rd_resp;

	always_comb begin
		rd_mux = '0;
		rd_resp = SCSB_RESP_OKAY;
		case (s_axi_araddr)
			SCSB_OFS_CLKMD: rd_mux[7:0] = clkmd_ff;
			SCSB_OFS_XTAL: rd_mux[7:0] = xtal_ff;
			SCSB_OFS_TRIM: rd_mux[7:0] = trim_ff;
			SCSB_OFS_STATUS: begin
				rd_mux[SCSB_ST_DONE] = core_rst_n_ff;
				rd_mux[SCSB_ST_SRC_LO +: 2] = cur_mode.src;
				rd_mux[SCSB_ST_WDT] = wdt_ff;
				rd_mux[SCSB_ST_FASTOPT] = fast_opt_ff;
			end
			default: rd_resp = SCSB_RESP_SLVERR;
		endcase
	end

	assign s_axi_arready = !rvalid_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= SCSB_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_mux;
			rresp_ff <= rd_resp;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	// ----------------------------------------------------------------
	// clock selection and outputs
	// ----------------------------------------------------------------
	scsb_clk_if clk_bus ();

	assign clk_bus.fast_edge = pin_rise[0] && clkmd_ff[SCSB_FAST_EN_BIT];
	assign clk_bus.slow_edge = pin_rise[1] && clkmd_ff[SCSB_SLOW_EN_BIT];
	assign clk_bus.xtal_edge = pin_rise[2] && xtal_ff[SCSB_XTAL_EN_BIT];
	// the boot-end load restarts too, or a count left over from /64 could pass the new last value
	assign clk_bus.restart = clkmd_wr || (state_ff == SCSB_ST_BOOT && boot_done); // RL14
	assign clk_bus.mode = cur_mode;

	scsb_clk_sel u_sel (
		.aclk(aclk),
		.aresetn(aresetn),
		.clk(clk_bus)
	);

	assign fast_rc_osc_en = clkmd_ff[SCSB_FAST_EN_BIT]; // RL1 RL2
	assign slow_rc_osc_en = clkmd_ff[SCSB_SLOW_EN_BIT]; // RL1 RL2 RL9
	assign crystal_osc_en = xtal_ff[SCSB_XTAL_EN_BIT]; // RL1
	assign crystal_drive = xtal_ff[SCSB_XTAL_DRV_LO +: 2];
	assign fast_rc_trim = trim_ff;
	assign sys_clk_tick = clk_bus.tick;
	assign core_reset_n = core_rst_n_ff;
	assign watchdog_en = wdt_ff;
endmodule
`default_nettype wire

// *** verification/scsb_chk.sv ***
// concurrent checks for the system clock select and boot block
// assumes it is bound to scsb_top and sees only that module's ports
`timescale 1ns/10ps
`default_nettype none
module scsb_chk
	import scsb_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic slow_rc_osc,
	input wire logic fast_boot_strap,
	input wire logic calibration_directive,
	input wire logic [7:0] calib_clkmd,
	input wire logic [7:0] calib_trim,
	input wire logic fast_rc_osc_en,
	input wire logic slow_rc_osc_en,
	input wire logic crystal_osc_en,
	input wire logic [7:0] fast_rc_trim,
	input wire logic core_reset_n,
	input wire logic watchdog_en
);
	localparam int FAST_LEN = 45;
	localparam int NORM_LEN = 3000;
	logic slow_s_ff;
	logic slow_d_ff;
	logic [2:0] cap_ff;
	logic [11:0] edges_ff;
	int boot_len;
	logic fast_code;
	logic slow_code;

	always_comb begin
		boot_len = fast_boot_strap ? FAST_LEN : NORM_LEN;
		fast_code = calibration_directive && (calib_clkmd inside {SCSB_CLKMD_DIV2, SCSB_CLKMD_DIV4,
			SCSB_CLKMD_DIV8, SCSB_CLKMD_DIV16, SCSB_CLKMD_DIV32});
		slow_code = calibration_directive && calib_clkmd == SCSB_CLKMD_SLOW;
	end

	// one sync stage only: our count leads the design's, so a late release shows
	always_ff @(posedge aclk) begin
		slow_s_ff <= slow_rc_osc;
		slow_d_ff <= slow_s_ff;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap_ff <= 3'h0;
			edges_ff <= 12'h000;
		end else if (cap_ff != 3'h3) begin
			cap_ff <= cap_ff + 3'h1;
		end else if (slow_s_ff && !slow_d_ff && slow_rc_osc_en && edges_ff != 12'hfff) begin
			edges_ff <= edges_ff + 12'h001;
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	enables_by_write_a: assert property (
		$changed({fast_rc_osc_en, slow_rc_osc_en, crystal_osc_en}) |-> $rose(s_axi_bvalid) || $rose(core_reset_n))
		else $error("oscillator enable moved without a write or boot end");
	boot_rc_on_a: assert property (
		$rose(core_reset_n) && !slow_code |-> fast_rc_osc_en && slow_rc_osc_en)
		else $error("rc oscillators not both running after boot");
	boot_not_early_a: assert property (
		core_reset_n |-> edges_ff >= boot_len)
		else $error("core released before the boot length");
	boot_not_late_a: assert property (
		!core_reset_n |-> edges_ff <= boot_len + 1)
		else $error("core held past the boot length");
	boot_wdt_on_a: assert property (
		!core_reset_n |-> watchdog_en)
		else $error("watchdog off during boot");
	trim_load_a: assert property (
		$rose(core_reset_n) && calibration_directive |-> fast_rc_trim == calib_trim)
		else $error("trim not loaded at boot end");
	slow_code_a: assert property (
		$rose(core_reset_n) && slow_code |-> watchdog_en && !fast_rc_osc_en && slow_rc_osc_en)
		else $error("slow selection state wrong at boot end");
	fast_code_a: assert property (
		$rose(core_reset_n) && fast_code |-> (!watchdog_en && slow_rc_osc_en) [*3])
		else $error("divided fast selection state wrong after boot");
	no_calib_a: assert property (
		$rose(core_reset_n) && !calibration_directive |-> watchdog_en ##1 watchdog_en)
		else $error("watchdog off without calibration");
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench for the system clock select and boot block
// assumes scsb_top with oscillators modelled as slow square waves on aclk
`timescale 1ns/10ps
`default_nettype none
module tb;
	import scsb_pkg::*;
	// oscillator periods in aclk cycles; slow rc kept short so a normal boot fits
	localparam int FP = 4;
	localparam int SP = 8;
	localparam int XP = 6;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic fast_rc_osc = 1'b0, slow_rc_osc = 1'b0, crystal_osc = 1'b0;
	logic fast_boot_strap = 1'b0, calibration_directive = 1'b0;
	logic [7:0] calib_clkmd = 8'h00, calib_trim = 8'h00;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, crystal_drive;
	logic [31:0] s_axi_rdata;
	logic fast_rc_osc_en, slow_rc_osc_en, crystal_osc_en, sys_clk_tick, core_reset_n, watchdog_en;
	logic [7:0] fast_rc_trim;
	logic [3:0] ph = 4'h0;
	int xc = 0;
	int fails = 0;
	int samples_checked = 0;

	scsb_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .fast_rc_osc, .slow_rc_osc, .crystal_osc, .fast_boot_strap, .calibration_directive,
		.calib_clkmd, .calib_trim, .fast_rc_osc_en, .slow_rc_osc_en, .crystal_osc_en, .crystal_drive,
		.fast_rc_trim, .sys_clk_tick, .core_reset_n, .watchdog_en);

	always #5 aclk = ~aclk;

	always @(posedge aclk) begin
		ph <= ph + 4'h1;
		xc <= (xc == XP - 1) ? 0 : xc + 1;
		fast_rc_osc <= ph[1];
		slow_rc_osc <= ph[2];
		crystal_osc <= xc < XP / 2;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic timeout();
		fails++;
		$display("CHECK FAILED at %0t: wait ran out", $time);
		conclude();
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
		int n;
		logic done;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {$urandom} << 8 | {24'h0, d};
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		done = 1'b0;
		r = 2'h3;
		for (n = 0; n < 60 && !done; n++) begin
			@(posedge aclk);
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				done = 1'b1;
			end
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		if (!done)
			timeout();
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic done;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		done = 1'b0;
		for (n = 0; n < 60 && !done; n++) begin
			@(posedge aclk);
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				done = 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		if (!done)
			timeout();
	endtask

	function automatic int exp_gap(input logic [7:0] c);
		case (c)
			8'h34: return 2 * FP;
			8'h14: return 4 * FP;
			8'h3c: return 8 * FP;
			8'h1c: return 16 * FP;
			8'h7c: return 32 * FP;
			8'h74: return 64 * FP;
			8'hb4: return XP;
			default: return SP;
		endcase
	endfunction

	// the first interval after a restart is partial, so the third tick is timed
	task automatic gap(input logic [7:0] c);
		int k;
		int n;
		for (k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(posedge aclk);
				n++;
			end while (sys_clk_tick !== 1'b1 && n < 600);
			if (sys_clk_tick !== 1'b1)
				timeout();
		end
		check(n, exp_gap(c), "tick period");
	endtask

	task automatic boot(input logic s, input logic dir, input logic [7:0] c);
		int n;
		int len;
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] ec;
		@(posedge aclk);
		aresetn <= 1'b0;
		fast_boot_strap <= s;
		calibration_directive <= dir;
		calib_clkmd <= c;
		calib_trim <= 8'($urandom);
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		for (n = 0; n < 30000 && core_reset_n !== 1'b1; n++)
			@(posedge aclk);
		if (core_reset_n !== 1'b1)
			timeout();
		len = s ? 45 : 3000;
		check(32'(n >= (len - 1) * SP && n <= (len + 1) * SP + 8), 32'h1, "boot length");
		ec = dir ? c : (s ? SCSB_CLKMD_RST_FAST : SCSB_CLKMD_RST_NORMAL);
		rd(SCSB_OFS_CLKMD, d, r);
		check(d, {24'h0, ec}, "clock mode after boot");
		check(32'({fast_rc_osc_en, slow_rc_osc_en}), 32'({ec[4], ec[2]}), "rc enables after boot");
		check(32'(watchdog_en), 32'(!(dir && c != SCSB_CLKMD_SLOW)), "watchdog after boot");
		check(32'(fast_rc_trim), 32'(dir ? calib_trim : SCSB_TRIM_RST), "trim after boot");
		gap(ec);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] v;
		static logic [7:0] codes [8] = '{8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c, 8'he4, 8'h74, 8'hb4};
		void'($urandom(1632));
		boot(1'b0, 1'b0, 8'h00);
		boot(1'b1, 1'b0, 8'h00);
		for (int i = 0; i < 6; i++)
			boot(1'b1, 1'b1, codes[i]);
		wr(SCSB_OFS_XTAL, 8'he0, r);
		check(32'({crystal_osc_en, crystal_drive}), 32'h7, "crystal enable");
		for (int i = 0; i < 8; i++) begin
			// both rc kept on, so no switch also stops the running source
			v = codes[i] | 8'h14;
			wr(SCSB_OFS_CLKMD, v, r);
			check(32'(r), 32'(SCSB_RESP_OKAY), "clock mode write");
			gap(v);
		end
		for (int i = 0; i < 8; i++) begin
			v = 8'($urandom);
			wr(SCSB_OFS_CLKMD, v | 8'h14, r);
			wr(SCSB_OFS_CLKMD, v, r);
			check(32'({fast_rc_osc_en, slow_rc_osc_en}), 32'({v[4], v[2]}), "rc enables");
			rd(SCSB_OFS_CLKMD, d, r);
			check(d, {24'h0, v}, "clock mode readback");
			v = 8'($urandom);
			wr(SCSB_OFS_XTAL, v, r);
			check(32'({crystal_osc_en, crystal_drive}), 32'(v[7:5]), "crystal control");
			wr(SCSB_OFS_TRIM, v, r);
			check(32'(fast_rc_trim), 32'(v), "trim write");
		end
		wr(SCSB_OFS_STATUS, 8'hff, r);
		check(32'(r), 32'(SCSB_RESP_OKAY), "status write");
		wr(4'h6, 8'h00, r);
		check(32'(r), 32'(SCSB_RESP_SLVERR), "unmapped write");
		rd(SCSB_OFS_STATUS, d, r);
		check(32'({d[4], d[0], r}), {30'h0, 2'h3} << 2 | 32'(SCSB_RESP_OKAY), "status");
		rd(4'h2, d, r);
		check({d[29:0], r}, 32'(SCSB_RESP_SLVERR), "unmapped read");
		conclude();
	end
endmodule

bind scsb_top scsb_chk chk_u (.aclk, .aresetn, .s_axi_bvalid, .slow_rc_osc, .fast_boot_strap,
	.calibration_directive, .calib_clkmd, .calib_trim, .fast_rc_osc_en, .slow_rc_osc_en, .crystal_osc_en,
	.fast_rc_trim, .core_reset_n, .watchdog_en);
`default_nettype wire
